// [core/lmcd_blink_gen.sv]
`default_nettype none
`include "lmcd_defs.svh"
module lmcd_blink_gen #(
    parameter int CNT_W = 26,
    parameter logic [CNT_W-1:0] STEP = CNT_W'(`LMCD_BLINK_STEP_CYC)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Control
    input wire logic run,
    // Phase count, bit 0 toggles each step
    output logic [1:0] phase
);

typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [1:0] phase;
} lmcd_blink_st_t;

lmcd_blink_st_t st_reg;
lmcd_blink_st_t st_next;

always_comb begin
    st_next = st_reg;
    if (!run) begin
        st_next.cnt = '0;
    end else if (st_reg.cnt >= STEP - CNT_W'(1)) begin
        st_next.cnt = '0;
        st_next.phase = st_reg.phase + 2'h1;
    end else begin
        st_next.cnt = st_reg.cnt + CNT_W'(1);
    end
end

always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        st_reg <= '0;
    end else begin
        st_reg <= st_next;
    end
end

assign phase = st_reg.phase;

endmodule
`default_nettype wire

// [core/lmcd_decoder.sv]
`default_nettype none
`include "lmcd_defs.svh"
module lmcd_decoder #(
    parameter int BLINK_W = 26,
    parameter logic [BLINK_W-1:0] BLINK_STEP_CYC = BLINK_W'(`LMCD_BLINK_STEP_CYC)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Wishbone slave
    input wire lmcd_pkg::lmcd_wb_req_t wbReq,
    output lmcd_pkg::lmcd_wb_rsp_t wbRsp,
    // Decoded settings toward the analog and scan logic
    output lmcd_pkg::lmcd_ctrl_t ctrlOut,
    // Static indicator drive
    output logic indicatorDriveOut
);

typedef struct packed {
    lmcd_pkg::lmcd_ctrl_t ctrl;
    logic ack;
    logic [31:0] rdata;
    logic indOut;
} lmcd_state_t;

lmcd_state_t st_reg;
lmcd_state_t st_next;
logic [1:0] blinkPhase;
logic blinkRun;

// Column stops at its top value instead of wrapping
function automatic logic [7:0] colInc(input logic [7:0] c);
    if (c >= `LMCD_COL_MAX) begin
        return c;
    end
    return c + 8'h01;
endfunction

// Standby keeps only the indicator alive, so power save picks by its state
function automatic lmcd_pkg::lmcd_ps_t psEntry(input logic [1:0] mode);
    if (mode != 2'h0) begin
        return lmcd_pkg::LMCD_PS_STANDBY;
    end
    return lmcd_pkg::LMCD_PS_SLEEP;
endfunction

function automatic logic [31:0] statusWord(input lmcd_pkg::lmcd_ctrl_t c);
    logic [31:0] w;
    w = 32'h0;
    w[0] = c.biasSel;
    w[1] = c.comReverse;
    w[2] = c.booster;
    w[3] = c.regulator;
    w[4] = c.follower;
    w[5] = c.rmw;
    w[6] = c.testMode;
    w[7] = c.displayOn;
    w[8] = c.allOn;
    w[11:9] = c.ps;
    w[14:12] = c.pend;
    return w;
endfunction

function automatic logic [31:0] settingWord(input lmcd_pkg::lmcd_ctrl_t c);
    logic [31:0] w;
    w = 32'h0;
    w[2:0] = c.ratio;
    w[9:4] = c.driveLevel;
    w[11:10] = c.indMode;
    w[19:12] = c.column;
    w[25:20] = c.startLine;
    w[29:26] = c.page;
    return w;
endfunction

// Blink steps only while the indicator has a supply to run on
assign blinkRun = (st_reg.ctrl.ps != lmcd_pkg::LMCD_PS_SLEEP);

lmcd_blink_gen #(
    .CNT_W(BLINK_W),
    .STEP(BLINK_STEP_CYC)
) u_blink (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(blinkRun),
    .phase(blinkPhase)
);

always_comb begin
    logic req;
    logic cmdWrite;
    logic [7:0] cb;
    logic isData;
    logic isRead;
    req = 1'b0;
    cmdWrite = 1'b0;
    cb = 8'h0;
    isData = 1'b0;
    isRead = 1'b0;
    st_next = st_reg;

    // Registered ack: one wait state, then dropped for a cycle
    req = wbReq.cyc && wbReq.stb && !st_reg.ack;
    st_next.ack = req;
    st_next.rdata = 32'h0;
    if (req && !wbReq.we) begin
        unique case (wbReq.adr)
            `LMCD_ADR_STATUS: begin
                st_next.rdata = statusWord(st_reg.ctrl);
            end
            `LMCD_ADR_SETTING: begin
                st_next.rdata = settingWord(st_reg.ctrl);
            end
            default: begin
                st_next.rdata = 32'h0;
            end
        endcase
    end

    // A command byte needs lanes 0 and 1 since the select bits sit in lane 1
    cmdWrite = req && wbReq.we && (wbReq.adr == `LMCD_ADR_CMD)
        && wbReq.sel[0] && wbReq.sel[1];
    cb = wbReq.dat[7:0];
    isData = wbReq.dat[`LMCD_CMD_DATA_BIT];
    isRead = wbReq.dat[`LMCD_CMD_READ_BIT];

    if (cmdWrite) begin
        if (st_reg.ctrl.pend != lmcd_pkg::LMCD_PD_NONE) begin
            if (!isData) begin
                if (st_reg.ctrl.pend == lmcd_pkg::LMCD_PD_VOLUME) begin
                    st_next.ctrl.driveLevel = cb[5:0];
                end else begin
                    st_next.ctrl.indMode = cb[1:0];
                end
                st_next.ctrl.pend = lmcd_pkg::LMCD_PD_NONE;
            end
        end else if (isData) begin
            if (!(isRead && st_reg.ctrl.rmw)) begin
                st_next.ctrl.column = colInc(st_reg.ctrl.column);
            end
        end else begin
            unique casez (cb)
                8'b1010_111?: begin
                    st_next.ctrl.displayOn = cb[0];
                    if (cb[0]) begin
                        st_next.ctrl.ps = lmcd_pkg::LMCD_PS_AWAKE;
                    end else if (st_reg.ctrl.allOn) begin
                        st_next.ctrl.ps = psEntry(st_reg.ctrl.indMode);
                    end
                end
                8'b1010_010?: begin
                    st_next.ctrl.allOn = cb[0];
                    if (!cb[0]) begin
                        st_next.ctrl.ps = lmcd_pkg::LMCD_PS_AWAKE;
                    end else if (!st_reg.ctrl.displayOn) begin
                        st_next.ctrl.ps = psEntry(st_reg.ctrl.indMode);
                    end
                end
                8'b01??_????: begin
                    st_next.ctrl.startLine = cb[5:0];
                end
                8'b1011_????: begin
                    if (cb[3:0] <= `LMCD_PAGE_MAX) begin
                        st_next.ctrl.page = cb[3:0];
                    end
                end
                8'b0001_????: begin
                    st_next.ctrl.column = {cb[3:0], st_reg.ctrl.column[3:0]};
                end
                8'b0000_????: begin
                    st_next.ctrl.column = {st_reg.ctrl.column[7:4], cb[3:0]};
                end
                8'b1010_001?: begin
                    if (st_reg.ctrl.follower) begin
                        st_next.ctrl.biasSel = cb[0];
                    end
                end
                `LMCD_OP_RMW: begin
                    if (!st_reg.ctrl.rmw) begin
                        st_next.ctrl.savedColumn = st_reg.ctrl.column;
                    end
                    st_next.ctrl.rmw = 1'b1;
                end
                `LMCD_OP_END: begin
                    if (st_reg.ctrl.rmw) begin
                        st_next.ctrl.column = st_reg.ctrl.savedColumn;
                    end
                    st_next.ctrl.rmw = 1'b0;
                end
                `LMCD_OP_RESET: begin
                    st_next.ctrl.startLine = 6'h0;
                    st_next.ctrl.column = 8'h0;
                    st_next.ctrl.page = 4'h0;
                    st_next.ctrl.comReverse = 1'b0;
                    st_next.ctrl.ratio = `LMCD_RST_RATIO;
                    st_next.ctrl.driveLevel = `LMCD_RST_DRIVE;
                    st_next.ctrl.indMode = 2'h0;
                    st_next.ctrl.rmw = 1'b0;
                    st_next.ctrl.testMode = 1'b0;
                    if (st_reg.ctrl.ps == lmcd_pkg::LMCD_PS_STANDBY) begin
                        st_next.ctrl.ps = lmcd_pkg::LMCD_PS_SLEEP;
                    end
                end
                `LMCD_OP_NOP: begin
                    st_next.ctrl.testMode = 1'b0;
                end
                8'b1100_????: begin
                    st_next.ctrl.comReverse = cb[3];
                end
                8'b0010_1???: begin
                    st_next.ctrl.booster = cb[2];
                    st_next.ctrl.regulator = cb[1];
                    st_next.ctrl.follower = cb[0];
                end
                8'b0010_0???: begin
                    st_next.ctrl.ratio = cb[2:0];
                end
                `LMCD_OP_VOLUME: begin
                    st_next.ctrl.pend = lmcd_pkg::LMCD_PD_VOLUME;
                end
                `LMCD_OP_IND_OFF: begin
                    st_next.ctrl.indMode = 2'h0;
                end
                `LMCD_OP_IND_ON: begin
                    st_next.ctrl.pend = lmcd_pkg::LMCD_PD_INDIC;
                end
                8'b1111_????: begin
                    st_next.ctrl.testMode = 1'b1;
                end
                default: begin
                    st_next.ctrl.testMode = st_reg.ctrl.testMode;
                end
            endcase
        end
    end

    if (st_reg.ctrl.ps == lmcd_pkg::LMCD_PS_SLEEP) begin
        st_next.indOut = 1'b0;
    end else begin
        unique case (st_reg.ctrl.indMode)
            2'h0: st_next.indOut = 1'b0;
            2'h1: st_next.indOut = blinkPhase[1];
            2'h2: st_next.indOut = blinkPhase[0];
            2'h3: st_next.indOut = 1'b1;
        endcase
    end
end

always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        st_reg <= '0;
        st_reg.ctrl.ratio <= `LMCD_RST_RATIO;
        st_reg.ctrl.driveLevel <= `LMCD_RST_DRIVE;
        st_reg.ctrl.ps <= lmcd_pkg::LMCD_PS_AWAKE;
        st_reg.ctrl.pend <= lmcd_pkg::LMCD_PD_NONE;
    end else begin
        st_reg <= st_next;
    end
end

assign wbRsp.ack = st_reg.ack;
assign wbRsp.dat = st_reg.rdata;
assign ctrlOut = st_reg.ctrl;
assign indicatorDriveOut = st_reg.indOut;

endmodule
`default_nettype wire

// [core/lmcd_defs.svh]
// Overview of operation
// - Bias command bit 0 selects 1/9 (0) or 1/7 (1) bias; the code loads it only while the follower is on.
// - In read/modify/write, reads keep the column; writes add one.
// - Read/modify/write lasts until the end command or a software reset arrives.
// - End command leaves the mode and restores the saved column.
// - Software reset reinitialises addresses, scan, ratio, contrast, indicator, modes.
// - Software reset leaves display RAM contents alone.
// - Common mode bit 3 picks forward or reverse scan; bits 2..0 ignored.
// - Power control bits 2,1,0 switch booster, regulator, follower.
// - Ratio command loads three low bits as divider ratio.
// - Contrast value byte stores six low bits, then leaves pending mode.
// - Only indicator commands and software reset change the static indicator mode.
// - Indicator ON waits for the register byte; OFF is one byte.
// - Indicator register byte loads two-bit blink mode and clears pending.
// - All-points-on while display off enters power save.
// - Mode 00 off, 01 one-second blink, 10 half-second blink, 11 on.
// - Power save is sleep with indicator off, standby with it on.
// - Software reset during standby moves to sleep.
`ifndef LMCD_DEFS_SVH
`define LMCD_DEFS_SVH

`define LMCD_ADR_CMD 4'h0
`define LMCD_ADR_STATUS 4'h4
`define LMCD_ADR_SETTING 4'h8

`define LMCD_CMD_DATA_BIT 8
`define LMCD_CMD_READ_BIT 9

`define LMCD_OP_RMW 8'hE0
`define LMCD_OP_END 8'hEE
`define LMCD_OP_RESET 8'hE2
`define LMCD_OP_NOP 8'hE3
`define LMCD_OP_VOLUME 8'h81
`define LMCD_OP_IND_OFF 8'hAC
`define LMCD_OP_IND_ON 8'hAD

`define LMCD_COL_MAX 8'h83
`define LMCD_PAGE_MAX 4'h8
`define LMCD_RST_RATIO 3'h0
`define LMCD_RST_DRIVE 6'h20

`define LMCD_CLK_KHZ 200000
`define LMCD_BLINK_STEP_MS 250
`define LMCD_BLINK_STEP_CYC (`LMCD_BLINK_STEP_MS * `LMCD_CLK_KHZ)

`endif

// [core/lmcd_pkg.sv]
`default_nettype none
package lmcd_pkg;

typedef enum logic [2:0] {
    LMCD_PS_AWAKE = 3'h1,
    LMCD_PS_SLEEP = 3'h2,
    LMCD_PS_STANDBY = 3'h4
} lmcd_ps_t;

typedef enum logic [2:0] {
    LMCD_PD_NONE = 3'h1,
    LMCD_PD_VOLUME = 3'h2,
    LMCD_PD_INDIC = 3'h4
} lmcd_pend_t;

typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
} lmcd_wb_req_t;

typedef struct packed {
    logic ack;
    logic [31:0] dat;
} lmcd_wb_rsp_t;

typedef struct packed {
    logic biasSel;
    logic comReverse;
    logic booster;
    logic regulator;
    logic follower;
    logic [2:0] ratio;
    logic [5:0] driveLevel;
    logic [1:0] indMode;
    logic [7:0] column;
    logic [7:0] savedColumn;
    logic rmw;
    logic testMode;
    logic [5:0] startLine;
    logic [3:0] page;
    logic displayOn;
    logic allOn;
    lmcd_ps_t ps;
    lmcd_pend_t pend;
} lmcd_ctrl_t;

endpackage
`default_nettype wire

// [verif/lmcd_chk_sva.sv]
`default_nettype none
`include "lmcd_defs.svh"
module lmcd_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Wishbone slave
    input wire lmcd_pkg::lmcd_wb_req_t wbReq,
    input wire lmcd_pkg::lmcd_wb_rsp_t wbRsp,
    // Decoded outputs
    input wire lmcd_pkg::lmcd_ctrl_t ctrlOut,
    input wire logic indicatorDriveOut
);
    logic take;
    logic idle;
    logic go;
    logic [7:0] cb;
    // Only writes enabling lanes 0 and 1 count; writes missing either lane are ignored by the block
    assign take = wbReq.cyc && wbReq.stb && !wbRsp.ack && wbReq.we
        && wbReq.adr == `LMCD_ADR_CMD && wbReq.sel[1:0] == 2'h3;
    assign idle = ctrlOut.pend == lmcd_pkg::LMCD_PD_NONE;
    assign go = take && !wbReq.dat[8] && idle;
    assign cb = wbReq.dat[7:0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_bias; go && cb[7:1] == 7'h51 && ctrlOut.follower
        |-> ##2 ctrlOut.biasSel == $past(cb[0], 2); endproperty
    a_bias: assert property (p_bias) else $error("bias bit not loaded");
    property p_rmwRead; take && wbReq.dat[9:8] == 2'h3 && idle && ctrlOut.rmw
        |-> ##2 ctrlOut.column == $past(ctrlOut.column, 2); endproperty
    a_rmwRead: assert property (p_rmwRead) else $error("column moved on read");
    property p_end; go && cb == `LMCD_OP_END && ctrlOut.rmw
        |-> ##2 !ctrlOut.rmw && ctrlOut.column == $past(ctrlOut.savedColumn, 2); endproperty
    a_end: assert property (p_end) else $error("end did not restore column");
    property p_reset; go && cb == `LMCD_OP_RESET |-> ##2 !ctrlOut.rmw && ctrlOut.column == 8'h0
        && ctrlOut.driveLevel == `LMCD_RST_DRIVE && ctrlOut.indMode == 2'h0
        && ctrlOut.ps != lmcd_pkg::LMCD_PS_STANDBY; endproperty
    a_reset: assert property (p_reset) else $error("soft reset incomplete");
    property p_scan; go && cb[7:4] == 4'hC
        |-> ##2 ctrlOut.comReverse == $past(cb[3], 2); endproperty
    a_scan: assert property (p_scan) else $error("scan direction wrong");
    property p_power; go && cb[7:3] == 5'h05 |-> ##2
        {ctrlOut.booster, ctrlOut.regulator, ctrlOut.follower} == $past(cb[2:0], 2); endproperty
    a_power: assert property (p_power) else $error("power bits wrong");
    property p_ratio; go && cb[7:3] == 5'h04
        |-> ##2 ctrlOut.ratio == $past(cb[2:0], 2); endproperty
    a_ratio: assert property (p_ratio) else $error("ratio wrong");
    property p_vol; take && !wbReq.dat[8] && ctrlOut.pend == lmcd_pkg::LMCD_PD_VOLUME
        |-> ##2 ctrlOut.driveLevel == $past(cb[5:0], 2) && ctrlOut.pend == 3'h1; endproperty
    a_vol: assert property (p_vol) else $error("contrast value wrong");
    property p_ind; take && !wbReq.dat[8] && ctrlOut.pend == lmcd_pkg::LMCD_PD_INDIC
        |-> ##2 ctrlOut.indMode == $past(cb[1:0], 2) && ctrlOut.pend == 3'h1; endproperty
    a_ind: assert property (p_ind) else $error("indicator mode wrong");
    property p_save; go && cb == 8'hA5 && !ctrlOut.displayOn |-> ##2 ctrlOut.ps ==
        (ctrlOut.indMode != 2'h0 ? lmcd_pkg::LMCD_PS_STANDBY : lmcd_pkg::LMCD_PS_SLEEP); endproperty
    a_save: assert property (p_save) else $error("power save mode wrong");
endmodule
bind lmcd_decoder lmcd_chk lmcd_chk_i (.ref_clk(ref_clk), .arst_n(arst_n), .wbReq(wbReq),
    .wbRsp(wbRsp), .ctrlOut(ctrlOut), .indicatorDriveOut(indicatorDriveOut));
`default_nettype wire

// [verif/lmcd_host.sv]
`default_nettype none
module lmcd_host (
    // Clock
    input wire logic ref_clk,
    // Wishbone master side
    output var lmcd_pkg::lmcd_wb_req_t wbReq,
    input wire lmcd_pkg::lmcd_wb_rsp_t wbRsp
);
    timeunit 1ns;
    timeprecision 100ps;
    initial wbReq = '0;
    // Released lines carry the inverse so stale values cannot pass
    task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge ref_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        do @(posedge ref_clk); while (wbRsp.ack !== 1'b1);
        wbReq <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~dat};
    endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
`default_nettype none
`include "lmcd_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    lmcd_pkg::lmcd_wb_req_t wbReq;
    lmcd_pkg::lmcd_wb_rsp_t wbRsp;
    lmcd_pkg::lmcd_ctrl_t ctrlOut;
    logic indicatorDriveOut;
    int miscompares = 0;
    int compares = 0;
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];
    logic [7:0] col;
    logic [2:0] pw;
    logic [2:0] rt;
    logic bias;
    logic [5:0] vol;
    always #2.5 ref_clk = ~ref_clk;
    lmcd_host lmcd_host_i (.ref_clk(ref_clk), .wbReq(wbReq), .wbRsp(wbRsp));
    // Short blink step keeps indicator checks quick
    lmcd_decoder #(.BLINK_STEP_CYC(26'h4)) lmcd_decoder_i (.ref_clk(ref_clk), .arst_n(arst_n),
        .wbReq(wbReq), .wbRsp(wbRsp), .ctrlOut(ctrlOut), .indicatorDriveOut(indicatorDriveOut));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Step of four cycles: half-second mode toggles every step, one-second every other
    task automatic blinkChk(input logic [1:0] m);
        int n;
        logic prev;
        n = 0;
        prev = indicatorDriveOut;
        repeat (32) begin
            @(posedge ref_clk);
            if (indicatorDriveOut !== prev) n++;
            prev = indicatorDriveOut;
        end
        check("blink toggles", (m == 2'h2) ? 32'h8 : ((m == 2'h1) ? 32'h4 : 32'h0), 32'(n));
    endtask
    task automatic cmd(input logic [7:0] b);
        lmcd_host_i.xfer(1'b1, `LMCD_ADR_CMD, {24'h0, b});
    endtask
    task automatic dacc(input logic isRd);
        lmcd_host_i.xfer(1'b1, `LMCD_ADR_CMD, {22'h0, isRd, 1'b1, 8'($urandom)});
    endtask
    task automatic rdChk(input logic [3:0] adr, input logic [31:0] msk, input logic [31:0] exp);
        expQ.push_back(exp);
        mskQ.push_back(msk);
        lmcd_host_i.xfer(1'b0, adr, 32'h0);
    endtask
    always @(posedge ref_clk) begin
        if (wbRsp.ack === 1'b1 && wbReq.we === 1'b0 && expQ.size() > 0) begin
            check("read data", expQ[0], wbRsp.dat & mskQ[0]);
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
    end
    task automatic conclude();
        $display("Counts: compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        conclude();
    end
    initial begin
        void'($urandom(74309));
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdChk(`LMCD_ADR_SETTING, 32'h3FFFFFF7, 32'h200);
        rdChk(`LMCD_ADR_STATUS, 32'h7FFF, 32'h1200);
        rdChk(4'hC, 32'hFFFFFFFF, 32'h0);
        $display("test reset values done");
        bias = 1'b0;
        for (int i = 0; i < 8; i++) begin
            pw = {2'($urandom), i[0]};
            rt = 3'($urandom);
            cmd({5'h05, pw});
            cmd({5'h04, rt});
            cmd({4'hC, i[1], 3'($urandom)});
            cmd({7'h51, i[2]});
            if (pw[0]) bias = i[2];
            rdChk(`LMCD_ADR_STATUS, 32'h1F, {27'h0, pw[0], pw[1], pw[2], i[1], bias});
            rdChk(`LMCD_ADR_SETTING, 32'h7, {29'h0, rt});
        end
        $display("test power and scan done");
        vol = 6'($urandom);
        cmd(`LMCD_OP_VOLUME);
        dacc(1'b0);
        rdChk(`LMCD_ADR_STATUS, 32'h7000, 32'h2000);
        cmd({2'h3, vol});
        rdChk(`LMCD_ADR_SETTING, 32'hFF3F0, {22'h0, vol, 4'h0});
        rdChk(`LMCD_ADR_STATUS, 32'h7000, 32'h1000);
        cmd(`LMCD_OP_VOLUME);
        cmd(8'h20);
        $display("test contrast done");
        for (int m = 0; m < 4; m++) begin
            cmd(`LMCD_OP_IND_ON);
            cmd({6'h3F, 2'(m)});
            cmd(8'h40);
            rdChk(`LMCD_ADR_SETTING, 32'hC00, {20'h0, 2'(m), 10'h0});
            blinkChk(2'(m));
        end
        repeat (3) @(posedge ref_clk);
        check("indicator on", 32'h1, {31'h0, indicatorDriveOut});
        cmd(`LMCD_OP_IND_OFF);
        rdChk(`LMCD_ADR_SETTING, 32'hC00, 32'h0);
        repeat (3) @(posedge ref_clk);
        check("indicator off", 32'h0, {31'h0, indicatorDriveOut});
        $display("test indicator done");
        col = 8'($urandom) & 8'h7F;
        cmd({4'h1, col[7:4]});
        cmd({4'h0, col[3:0]});
        cmd(`LMCD_OP_RMW);
        dacc(1'b0);
        dacc(1'b1);
        dacc(1'b0);
        rdChk(`LMCD_ADR_SETTING, 32'hFF000, {12'h0, 8'(col + 8'h2), 12'h0});
        rdChk(`LMCD_ADR_STATUS, 32'h20, 32'h20);
        cmd(`LMCD_OP_END);
        rdChk(`LMCD_ADR_SETTING, 32'hFF000, {12'h0, col, 12'h0});
        $display("test read modify write done");
        cmd(`LMCD_OP_IND_ON);
        cmd(8'h01);
        cmd(`LMCD_OP_RMW);
        cmd(8'hAE);
        cmd(8'hA5);
        rdChk(`LMCD_ADR_STATUS, 32'hE20, 32'h820);
        cmd(`LMCD_OP_RESET);
        rdChk(`LMCD_ADR_STATUS, 32'hE22, 32'h400);
        rdChk(`LMCD_ADR_SETTING, 32'h3FFFFFF7, 32'h200);
        $display("test power save done");
        repeat (2) @(posedge ref_clk);
        conclude();
    end
endmodule
`default_nettype wire
